// ==== hdl/tsrb_defs.svh ====
// Constants for the transparent serial-to-radio bridge.
// Assumes a single 250 MHz module clock; included by bare name.
`ifndef TSRB_DEFS_SVH
`define TSRB_DEFS_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define TSRB_CLK_HZ         250000000
`define TSRB_CLK_KHZ        250000
`define TSRB_IDLE_MS        20
`define TSRB_IDLE_CYCLES    (`TSRB_IDLE_MS * `TSRB_CLK_KHZ)
`define TSRB_BAUD_DFLT      115200
`define TSRB_BAUD_DIV_DFLT  (`TSRB_CLK_HZ / `TSRB_BAUD_DFLT)

// ---------------------------------------------------------------
// Buffer and link payload limits
// ---------------------------------------------------------------
`define TSRB_BUF_BYTES      1015
`define TSRB_PAY_MAX        8'hF3
`define TSRB_PAY_LEGACY     8'h13
`define TSRB_MTU_MAX        9'h0F7

// ---------------------------------------------------------------
// Advertised name and information fields
// ---------------------------------------------------------------
`define TSRB_NAME_PREFIX    16'h412D
`define TSRB_LONG_TEXT_MAX  7'h40
`define TSRB_SHORT_TEXT_MAX 7'h10
`define TSRB_INFO_FIELDS    5

`endif

// ==== hdl/tsrb_pkg.sv ====
// Types shared by the bridge files.
// Assumes tsrb_defs.svh supplies the numeric constants.
package tsrb_pkg;

  // ---------------------------------------------------------------
  // Packet engine states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TSRB_COLLECT = 2'b00,
    TSRB_WAIT_EV = 2'b01,
    TSRB_SEND    = 2'b10
  } tsrb_state_t;

endpackage

// ==== hdl/tsrb_uart_rx.sv ====
// Serial receiver, 8 data bits, no parity, one stop bit.
// Assumes the line idles high and div is at least 4 clock cycles.
`timescale 1ns/100ps
`include "tsrb_defs.svh"

module tsrb_uart_rx #(
  parameter int DIV_W = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic [DIV_W-1:0] div,
  input  wire logic             rx_pin,
  output logic      [7:0]       data,
  output logic                  valid
);

  logic             sync1_r;
  logic             sync2_r;
  logic             busy_r;
  logic [DIV_W-1:0] cnt_r;
  logic [3:0]       bit_r;
  logic [7:0]       shift_r;

  wire              tick      = (cnt_r == '0);
  wire              start_seen = enable && !busy_r && !sync2_r;
  wire [DIV_W-1:0]  half_div  = div >> 1;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= rx_pin;
      sync2_r <= sync1_r;
    end
  end

  // ---------------------------------------------------------------
  // Bit sampler
  // ---------------------------------------------------------------
  // Sampling starts half a bit after the falling edge, so each bit is
  // taken near its centre.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_r  <= 1'b0;
      cnt_r   <= '0;
      bit_r   <= 4'h0;
      shift_r <= 8'h00;
      data    <= 8'h00;
      valid   <= 1'b0;
    end else begin
      valid <= 1'b0;
      if (!enable) begin
        busy_r <= 1'b0;
      end else if (start_seen) begin
        busy_r <= 1'b1;
        cnt_r  <= half_div;
        bit_r  <= 4'h0;
      end else if (busy_r) begin
        cnt_r <= tick ? div - 1'b1 : cnt_r - 1'b1;
        if (tick) begin
          bit_r <= bit_r + 4'h1;
          if (bit_r == 4'h0 && sync2_r) begin
            busy_r <= 1'b0;
          end else if (bit_r == 4'h9) begin
            busy_r <= 1'b0;
            if (sync2_r) begin
              data  <= shift_r;
              valid <= 1'b1;
            end
          end else if (bit_r != 4'h0) begin
            shift_r <= {sync2_r, shift_r[7:1]};
          end
        end
      end
    end
  end

endmodule

// ==== hdl/tsrb_bridge.sv ====
// Transparent serial-to-radio bridge, top level.
// Assumes radio-side signals come from logic on the same clock;
// strap, serial receive and clear-to-send are asynchronous pins.
//
// Operation
// - Strap high at reset release selects bridge mode; low selects command mode.
// - Factory serial setting is 115200 baud 8n1 with a fixed pairing key.
// - Host bytes collect in a buffer of at most 1015 payload bytes.
// - After 20 ms without a new byte the packet closes and is sent.
// - Oversize packets split into fragments, one per connection interval.
// - Fragments carry up to 243 bytes when a 247 byte transfer unit is agreed.
// - Without a transfer-unit request each fragment carries up to 19 bytes.
// - Busy output is low by default so the host may send.
// - Busy rises on idle timeout or full buffer; sending starts at the next connection interval.
// - Busy falls once every fragment of the packet has been sent.
// - Serial input is discarded while busy; the host holds off.
// - Advertised name is a two-character prefix plus six address hex digits.
// - Bridge mode drops the transmit-power element; beacon setting may adjust.
// - Long text fields take up to 64 bytes, revision fields 16.
// - An information field is published only when its select bit is set.
// - A two-byte appearance value comes from its setting.
// - The serial flow setting enables hardware flow control.
// - Serial port is enabled only while a radio channel is open.
// - Radio data goes to the host as raw bytes without header.
`timescale 1ns/100ps
`include "tsrb_defs.svh"

module tsrb_bridge #(
  parameter int IDLE_CYCLES = `TSRB_IDLE_CYCLES,
  parameter int BUF_BYTES   = `TSRB_BUF_BYTES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        strap_select_pin,
  input  wire logic [15:0] serial_rate_setting,
  input  wire logic        serial_flow_setting,
  input  wire logic [19:0] fixed_pairing_key,
  input  wire logic        beacon_content_setting,
  input  wire logic [47:0] factory_radio_address,
  input  wire logic [15:0] appearance_setting,
  input  wire logic [4:0]  info_field_select,
  input  wire logic [34:0] info_text_len,
  input  wire logic        link_open,
  input  wire logic        unit_requested,
  input  wire logic [8:0]  unit_size,
  input  wire logic        conn_event,
  input  wire logic        radio_tx_ready,
  input  wire logic [7:0]  radio_rx_data,
  input  wire logic        radio_rx_valid,
  input  wire logic        serial_rx,
  input  wire logic        serial_cts_n,
  output logic             bridge_mode,
  output logic             serial_enable,
  output logic             serial_tx,
  output logic             busy,
  output logic [7:0]       radio_tx_data,
  output logic             radio_tx_valid,
  output logic             radio_tx_last,
  output logic             radio_rx_ready,
  output logic [63:0]      adv_name,
  output logic             adv_power_element,
  output logic [19:0]      pairing_key,
  output logic [15:0]      appearance_value,
  output logic [4:0]       info_publish,
  output logic [34:0]      info_publish_len
);

  localparam int AW = $clog2(BUF_BYTES + 1);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'hA) ? 8'h30 + {4'h0, nib} : 8'h37 + {4'h0, nib};
  endfunction

  function automatic logic [6:0] clamp_len(input logic [6:0] len, input logic [6:0] lim);
    clamp_len = (len > lim) ? lim : len;
  endfunction

  // ---------------------------------------------------------------
  // Strap capture and pin synchronisers
  // ---------------------------------------------------------------
  logic strap1_r, strap2_r, strap_taken_r;
  logic cts1_r, cts2_r;

  // No reset on the strap flops, so the pin level is already settled when reset lets go
  always_ff @(posedge clock) begin
    strap1_r <= strap_select_pin;
    strap2_r <= strap1_r;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cts1_r   <= 1'b1;
      cts2_r   <= 1'b1;
    end else begin
      cts1_r   <= serial_cts_n;
      cts2_r   <= cts1_r;
    end
  end

  // Mode is caught once after release; later strap changes are ignored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_taken_r <= 1'b0;
      bridge_mode   <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      bridge_mode   <= strap2_r;
    end
  end

  // ---------------------------------------------------------------
  // Static settings published to the radio stack
  // ---------------------------------------------------------------
  logic [63:0] name_nxt;
  logic [34:0] len_nxt;

  always_comb begin
    name_nxt = {`TSRB_NAME_PREFIX, 48'h0};
    for (int i = 0; i < 6; i++) begin
      name_nxt[8*i +: 8] = hex_char(factory_radio_address[4*i +: 4]);
    end
  end

  always_comb begin
    len_nxt = '0;
    for (int f = 0; f < `TSRB_INFO_FIELDS; f++) begin
      len_nxt[7*f +: 7] = clamp_len(info_text_len[7*f +: 7],
                                   (f < 3) ? `TSRB_LONG_TEXT_MAX : `TSRB_SHORT_TEXT_MAX);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      adv_name          <= 64'h0;
      adv_power_element <= 1'b1;
      pairing_key       <= 20'h0;
      appearance_value  <= 16'h0;
      info_publish      <= 5'h0;
      info_publish_len  <= 35'h0;
    end else begin
      adv_name          <= name_nxt;
      adv_power_element <= !bridge_mode && !beacon_content_setting;
      pairing_key       <= fixed_pairing_key;
      appearance_value  <= appearance_setting;
      info_publish      <= info_field_select;
      info_publish_len  <= len_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Serial receiver
  // ---------------------------------------------------------------
  logic [7:0] rx_byte;
  logic       rx_valid;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_enable <= 1'b0;
    end else begin
      serial_enable <= bridge_mode && link_open;
    end
  end

  tsrb_uart_rx #(
    .DIV_W (16)
  ) u_rx (
    .clock  (clock),
    .rst    (rst),
    .enable (serial_enable),
    .div    (serial_rate_setting),
    .rx_pin (serial_rx),
    .data   (rx_byte),
    .valid  (rx_valid)
  );

  // ---------------------------------------------------------------
  // Packet engine
  // ---------------------------------------------------------------
  logic [7:0]          buf_mem [BUF_BYTES];
  tsrb_pkg::tsrb_state_t state_r;
  logic [AW-1:0]       wcnt_r;
  logic [AW-1:0]       rd_r;
  logic [7:0]          fcnt_r;
  logic [31:0]         idle_r;

  wire  [7:0] unit_pay  = (unit_size > `TSRB_MTU_MAX) ? `TSRB_PAY_MAX : 8'(unit_size - 9'h004);
  wire  [7:0] frag_max  = unit_requested ? unit_pay : `TSRB_PAY_LEGACY;
  wire        take_byte = rx_valid && (state_r == tsrb_pkg::TSRB_COLLECT);
  wire        buf_full  = take_byte && (wcnt_r == AW'(BUF_BYTES - 1));
  wire        idle_done = (wcnt_r != '0) && (idle_r == IDLE_CYCLES - 1);
  wire        pkt_end   = (rd_r == wcnt_r - 1'b1);
  // Used only for the first byte of a fragment, whose count is zero
  wire        frag_end  = pkt_end || (frag_max == 8'h01);
  wire        tx_done   = radio_tx_valid && radio_tx_ready;
  wire [AW-1:0] rd_inc  = rd_r + 1'b1;

  always_ff @(posedge clock) begin
    if (take_byte) begin
      buf_mem[wcnt_r] <= rx_byte;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r        <= tsrb_pkg::TSRB_COLLECT;
      wcnt_r         <= '0;
      rd_r           <= '0;
      fcnt_r         <= 8'h00;
      idle_r         <= 32'h0;
      busy           <= 1'b0;
      radio_tx_data  <= 8'h00;
      radio_tx_valid <= 1'b0;
      radio_tx_last  <= 1'b0;
    end else if (!serial_enable) begin
      // A dropped channel abandons the packet and frees the host
      state_r        <= tsrb_pkg::TSRB_COLLECT;
      wcnt_r         <= '0;
      rd_r           <= '0;
      idle_r         <= 32'h0;
      busy           <= 1'b0;
      radio_tx_valid <= 1'b0;
      radio_tx_last  <= 1'b0;
    end else begin
      unique case (state_r)
        tsrb_pkg::TSRB_COLLECT: begin
          if (take_byte) begin
            wcnt_r <= wcnt_r + 1'b1;
            idle_r <= 32'h0;
          end else if (wcnt_r != '0) begin
            idle_r <= idle_r + 32'h1;
          end
          if (buf_full || idle_done) begin
            busy    <= 1'b1;
            state_r <= tsrb_pkg::TSRB_WAIT_EV;
          end
        end
        tsrb_pkg::TSRB_WAIT_EV: begin
          if (conn_event) begin
            state_r        <= tsrb_pkg::TSRB_SEND;
            fcnt_r         <= 8'h00;
            radio_tx_data  <= buf_mem[rd_r];
            radio_tx_valid <= 1'b1;
            radio_tx_last  <= frag_end;
          end
        end
        tsrb_pkg::TSRB_SEND: begin
          if (tx_done) begin
            if (radio_tx_last) begin
              radio_tx_valid <= 1'b0;
              radio_tx_last  <= 1'b0;
              if (pkt_end) begin
                // Buffer is emptied here; the timer stays still until a byte
                busy    <= 1'b0;
                wcnt_r  <= '0;
                rd_r    <= '0;
                idle_r  <= 32'h0;
                state_r <= tsrb_pkg::TSRB_COLLECT;
              end else begin
                rd_r    <= rd_inc;
                state_r <= tsrb_pkg::TSRB_WAIT_EV;
              end
            end else begin
              rd_r          <= rd_inc;
              fcnt_r        <= fcnt_r + 8'h01;
              radio_tx_data <= buf_mem[rd_inc];
              radio_tx_last <= (rd_inc == wcnt_r - 1'b1) || (fcnt_r + 8'h01 == frag_max - 8'h01);
            end
          end
        end
        default: begin
          state_r <= tsrb_pkg::TSRB_COLLECT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Radio-to-serial path
  // ---------------------------------------------------------------
  // One byte of holding only; the radio side is stalled by ready
  // while the held byte waits to go out on the wire.
  logic [9:0]  tx_shift_r;
  logic [3:0]  tx_bits_r;
  logic [15:0] tx_cnt_r;
  logic        hold_r;
  logic [7:0]  hold_data_r;

  wire tx_idle  = (tx_bits_r == 4'h0);
  wire cts_ok   = !serial_flow_setting || !cts2_r;
  wire tx_start = hold_r && tx_idle && cts_ok;
  wire rx_take  = radio_rx_valid && radio_rx_ready;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_shift_r     <= 10'h3FF;
      tx_bits_r      <= 4'h0;
      tx_cnt_r       <= 16'h0000;
      hold_r         <= 1'b0;
      hold_data_r    <= 8'h00;
      radio_rx_ready <= 1'b0;
      serial_tx      <= 1'b1;
    end else begin
      radio_rx_ready <= serial_enable && !hold_r && !rx_take;
      if (rx_take) begin
        hold_r      <= 1'b1;
        hold_data_r <= radio_rx_data;
      end
      if (tx_start) begin
        hold_r     <= 1'b0;
        tx_shift_r <= {1'b1, hold_data_r, 1'b0};
        tx_bits_r  <= 4'hA;
        tx_cnt_r   <= 16'h0000;
      end else if (!tx_idle) begin
        if (tx_cnt_r == serial_rate_setting - 16'h0001) begin
          tx_cnt_r   <= 16'h0000;
          tx_shift_r <= {1'b1, tx_shift_r[9:1]};
          tx_bits_r  <= tx_bits_r - 4'h1;
        end else begin
          tx_cnt_r <= tx_cnt_r + 16'h0001;
        end
      end
      serial_tx <= tx_start ? 1'b0 : (tx_idle ? 1'b1 : tx_shift_r[0]);
    end
  end

endmodule

// ==== dv/tsrb_bridge_chk.sv ====
// Port checker for the serial-to-radio bridge, bound to tsrb_bridge.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/100ps
module tsrb_bridge_chk #(
  parameter int IDLE_CYCLES = 200,
  parameter int BUF_BYTES   = 1015
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        link_open,
  input wire logic        conn_event,
  input wire logic        radio_tx_ready,
  input wire logic [15:0] appearance_setting,
  input wire logic [4:0]  info_field_select,
  input wire logic        bridge_mode,
  input wire logic        serial_enable,
  input wire logic        serial_tx,
  input wire logic        busy,
  input wire logic [7:0]  radio_tx_data,
  input wire logic        radio_tx_valid,
  input wire logic        radio_tx_last,
  input wire logic [63:0] adv_name,
  input wire logic        adv_power_element,
  input wire logic [15:0] appearance_value,
  input wire logic [4:0]  info_publish
);
  // ----------------------------------------
  // Bytes handed to the radio in one packet
  // ----------------------------------------
  int sent_cnt;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) sent_cnt <= 0;
    else if (!busy) sent_cnt <= 0;
    else if (radio_tx_valid && radio_tx_ready) sent_cnt <= sent_cnt + 1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_busy_rst; $fell(rst) |-> !busy && serial_tx; endproperty
  a_busy_rst: assert property (p_busy_rst) else $error("busy or serial line wrong after reset");
  property p_valid_busy; radio_tx_valid |-> busy; endproperty
  a_valid_busy: assert property (p_valid_busy) else $error("radio data without busy");
  property p_frag_start; $rose(radio_tx_valid) |-> $past(conn_event); endproperty
  a_frag_start: assert property (p_frag_start) else $error("fragment began without interval");
  property p_frag_end; radio_tx_valid && radio_tx_ready && radio_tx_last |=> !radio_tx_valid; endproperty
  a_frag_end: assert property (p_frag_end) else $error("second fragment in one interval");
  property p_hold;
    radio_tx_valid && !radio_tx_ready && link_open |=>
      radio_tx_valid && $stable(radio_tx_data) && $stable(radio_tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("radio byte changed before acceptance");
  property p_busy_fall;
    $fell(busy) |-> $past(radio_tx_valid && radio_tx_ready && radio_tx_last) || !$past(link_open);
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell before last fragment");
  property p_port_en; serial_enable == $past(bridge_mode && link_open); endproperty
  a_port_en: assert property (p_port_en) else $error("serial port enable wrong");
  property p_name; bridge_mode && $past(bridge_mode, 2) |-> adv_name[63:48] == 16'h412D && !adv_power_element;
  endproperty
  a_name: assert property (p_name) else $error("bridge name prefix or power element wrong");
  property p_appear; !$past(rst) |-> appearance_value == $past(appearance_setting); endproperty
  a_appear: assert property (p_appear) else $error("appearance value wrong");
  property p_select; !$past(rst) |-> info_publish == $past(info_field_select); endproperty
  a_select: assert property (p_select) else $error("field publish bits wrong");
  property p_buf; sent_cnt <= BUF_BYTES; endproperty
  a_buf: assert property (p_buf) else $error("packet longer than buffer");
endmodule

bind tsrb_bridge tsrb_bridge_chk #(.IDLE_CYCLES(IDLE_CYCLES), .BUF_BYTES(BUF_BYTES)) tsrb_bridge_chk_inst (
  .clock, .rst, .link_open, .conn_event, .radio_tx_ready, .appearance_setting, .info_field_select,
  .bridge_mode, .serial_enable, .serial_tx, .busy, .radio_tx_data, .radio_tx_valid, .radio_tx_last,
  .adv_name, .adv_power_element, .appearance_value, .info_publish);

// ==== dv/tsrb_host_model.sv ====
// Host controller model on the serial side of the bridge.
// Assumes DIV equals the bridge's bit divisor setting.
`timescale 1ns/100ps
module tsrb_host_model #(
  parameter int DIV = 8
) (
  input  wire logic clock,
  input  wire logic busy,
  input  wire logic serial_tx,
  output logic      serial_rx,
  output logic      serial_cts_n
);
  // ----------------------------------------
  // Line idles high
  // ----------------------------------------
  initial begin
    serial_rx = 1'b1;
  end

  // Clear-to-send is driven only here; the bench may hold the bridge off
  task automatic hold_off(input logic v);
    serial_cts_n <= v;
  endtask

  // A rude send ignores busy on purpose, to prove the bridge drops it
  task automatic send(input logic [7:0] b, input bit rude);
    logic [9:0] frame;
    int i;
    frame = {1'b1, b, 1'b0};
    while (busy !== 1'b0 && !rude) @(posedge clock);
    for (i = 0; i < 10; i++) begin
      serial_rx <= frame[i];
      repeat (DIV) @(posedge clock);
    end
  endtask

  task automatic take(output logic [7:0] b);
    int i;
    b = 8'h00;
    for (i = 0; i < 2000 && serial_tx !== 1'b0; i++) @(posedge clock);
    repeat (DIV + DIV / 2) @(posedge clock);
    for (i = 0; i < 8; i++) begin
      b[i] = serial_tx;
      repeat (DIV) @(posedge clock);
    end
  endtask
endmodule

// ==== dv/tb_tsrb_bridge.sv ====
// Self-checking bench for the serial-to-radio bridge.
// Assumes the host model on the serial side; the bench plays the radio.
`timescale 1ns/100ps
`define TSRB_CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t line %0d: got %0h want %0h", $time, `__LINE__, got, exp); end end

module tb_tsrb_bridge;
  localparam int IDLE = 200;
  localparam int BUFB = 250;
  localparam int DIV  = 8;
  logic        clock, rst, strap_select_pin, serial_flow_setting, beacon_content_setting, link_open;
  logic        unit_requested, conn_event, radio_tx_ready, radio_rx_valid, serial_rx, serial_cts_n;
  logic        bridge_mode, serial_enable, serial_tx, busy, radio_tx_valid, radio_tx_last, radio_rx_ready;
  logic        adv_power_element;
  logic [15:0] serial_rate_setting, appearance_setting, appearance_value;
  logic [19:0] fixed_pairing_key, pairing_key;
  logic [47:0] factory_radio_address;
  logic [4:0]  info_field_select, info_publish;
  logic [34:0] info_text_len, info_publish_len;
  logic [8:0]  unit_size;
  logic [7:0]  radio_rx_data, radio_tx_data;
  logic [63:0] adv_name;
  logic [1:0]  stall = 2'h0;
  logic [7:0]  got_q[$];
  int          frag_q[$];
  int          bad_count, n_checks;

  // Short idle timeout and buffer keep the run brief
  tsrb_bridge #(.IDLE_CYCLES(IDLE), .BUF_BYTES(BUFB)) tsrb_bridge_inst (
    .clock, .rst, .strap_select_pin, .serial_rate_setting, .serial_flow_setting, .fixed_pairing_key,
    .beacon_content_setting, .factory_radio_address, .appearance_setting, .info_field_select, .info_text_len,
    .link_open, .unit_requested, .unit_size, .conn_event, .radio_tx_ready, .radio_rx_data, .radio_rx_valid,
    .serial_rx, .serial_cts_n, .bridge_mode, .serial_enable, .serial_tx, .busy, .radio_tx_data,
    .radio_tx_valid, .radio_tx_last, .radio_rx_ready, .adv_name, .adv_power_element, .pairing_key,
    .appearance_value, .info_publish, .info_publish_len);
  tsrb_host_model #(.DIV(DIV)) tsrb_host_model_inst (.clock, .busy, .serial_tx, .serial_rx, .serial_cts_n);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------
  // Radio sink, stalling one cycle in four
  // ----------------------------------------
  always @(posedge clock) begin
    if (radio_tx_valid === 1'b1 && radio_tx_ready === 1'b1) begin
      got_q.push_back(radio_tx_data);
      if (radio_tx_last === 1'b1) frag_q.push_back(got_q.size());
    end
    stall <= stall + 2'h1;
    radio_tx_ready <= (stall != 2'h0);
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic do_reset(input logic strap);
    strap_select_pin <= strap;
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task automatic packet(input int n, input int f, input logic [7:0] base, input bit full);
    int k, t;
    got_q = {};
    frag_q = {};
    for (k = 0; k < n; k++) begin
      tsrb_host_model_inst.send(base + 8'(k), 1'b0);
      if (k == 5) begin
        repeat (IDLE - 12 * DIV) @(posedge clock);
        `TSRB_CHECK(busy, 1'b0)
      end
    end
    if (full) begin
      repeat (2) @(posedge clock);
      `TSRB_CHECK(busy, 1'b1)
      tsrb_host_model_inst.send(8'hEE, 1'b1);
    end else begin
      repeat (IDLE - 3 * DIV) @(posedge clock);
      `TSRB_CHECK(busy, 1'b0)
      for (t = 0; t < 6 * DIV && busy !== 1'b1; t++) @(posedge clock);
      `TSRB_CHECK(busy, 1'b1)
    end
    for (k = 0; k * f < n; k++) begin
      `TSRB_CHECK(busy, 1'b1)
      conn_event <= 1'b1;
      @(posedge clock);
      conn_event <= 1'b0;
      for (t = 0; t < 4000 && frag_q.size() <= k; t++) @(posedge clock);
      repeat (20) @(posedge clock);
      `TSRB_CHECK(got_q.size(), ((k + 1) * f < n) ? (k + 1) * f : n)
    end
    `TSRB_CHECK(busy, 1'b0)
    for (k = 0; k < n; k++) `TSRB_CHECK(got_q[k], base + 8'(k))
  endtask

  task automatic to_host(input logic [7:0] b);
    logic [7:0] r;
    int t;
    radio_rx_data <= b;
    radio_rx_valid <= 1'b1;
    @(posedge clock);
    for (t = 0; t < 100 && radio_rx_ready !== 1'b1; t++) @(posedge clock);
    radio_rx_valid <= 1'b0;
    tsrb_host_model_inst.take(r);
    `TSRB_CHECK(r, b)
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    $display("unexpected at %0t: run did not complete", $time);
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    strap_select_pin = 1'b1;
    serial_flow_setting = 1'b1;
    beacon_content_setting = 1'b0;
    link_open = 1'b1;
    unit_requested = 1'b0;
    unit_size = 9'h1FF;
    conn_event = 1'b0;
    radio_rx_valid = 1'b0;
    radio_rx_data = 8'h00;
    tsrb_host_model_inst.hold_off(1'b0);
    serial_rate_setting = 16'h0008;
    appearance_setting = 16'hC3A1;
    fixed_pairing_key = 20'h1E0DB;
    factory_radio_address = 48'h5A5A5A9E0F7C;
    info_field_select = 5'h15;
    info_text_len = {7'h10, 7'h11, 7'h41, 7'h20, 7'h7F};
    bad_count = 0;
    n_checks = 0;
    @(posedge clock);
    do_reset(1'b1);
    `TSRB_CHECK(bridge_mode, 1'b1)
    `TSRB_CHECK(busy, 1'b0)
    `TSRB_CHECK(serial_enable, 1'b1)
    `TSRB_CHECK(adv_name, 64'h412D394530463743)
    `TSRB_CHECK(adv_power_element, 1'b0)
    `TSRB_CHECK(pairing_key, 20'h1E0DB)
    `TSRB_CHECK(appearance_value, 16'hC3A1)
    `TSRB_CHECK(info_publish_len, {7'h10, 7'h10, 7'h40, 7'h20, 7'h40})
    info_field_select <= 5'h0A;
    repeat (3) @(posedge clock);
    `TSRB_CHECK(info_publish, 5'h0A)
    packet(25, 19, 8'h30, 1'b0);
    unit_requested <= 1'b1;
    unit_size <= 9'h010;
    packet(30, 12, 8'h80, 1'b0);
    unit_size <= 9'h1FF;
    packet(BUFB, 243, 8'h00, 1'b1);
    to_host(8'hA5);
    tsrb_host_model_inst.hold_off(1'b1);
    fork
      to_host(8'h3C);
      begin
        repeat (20) @(posedge clock);
        `TSRB_CHECK(serial_tx, 1'b1)
        tsrb_host_model_inst.hold_off(1'b0);
      end
    join
    link_open <= 1'b0;
    repeat (3) @(posedge clock);
    `TSRB_CHECK(serial_enable, 1'b0)
    beacon_content_setting <= 1'b1;
    do_reset(1'b0);
    `TSRB_CHECK(bridge_mode, 1'b0)
    `TSRB_CHECK(adv_power_element, 1'b0)
    beacon_content_setting <= 1'b0;
    repeat (3) @(posedge clock);
    `TSRB_CHECK(adv_power_element, 1'b1)
    wrap_up();
  end
endmodule
